// file: cycle_timing_defines.svh
// timing and field constants for the machine-cycle sequencer
`ifndef CYCLE_TIMING_DEFINES_SVH
`define CYCLE_TIMING_DEFINES_SVH
`define CLK_PERIOD_NS 10
`define OSC_PER_MC 3'h4
`define PHASE_LAST 2'h3
`define TMR_DIV_SLOW 4'hc
`define TMR_DIV_FAST 4'h4
`define MC_MAX 3'h5
`define MC_MIN 3'h1
`define XDATA_BASE_MC 3'h2
`define STRETCH_MAX 3'h7
`define SHORT_ADDR_W 11
`define LONG_ADDR_W 16
`endif

// file: cycle_timing_pkg.sv
// types shared by the sequencer modules
package cycle_timing_pkg;
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_EXEC = 2'b01,
    ST_XDATA = 2'b10
  } seq_state_t;
  typedef enum logic [1:0] {
    IND_R0 = 2'b00,
    IND_R1 = 2'b01
  } ind_sel_t;
endpackage : cycle_timing_pkg

// file: phase_if.sv
// phase and machine-cycle signals between the phase counter and sequencer
`timescale 1ns/1ps
`default_nettype none
interface phase_if;
  logic [1:0] phase;
  logic mc_end;
  logic ale;
  modport gen (output phase, output mc_end, output ale);
  modport use_side (input phase, input mc_end, input ale);
endinterface : phase_if
`default_nettype wire

// file: phase_counter.sv
// four-clock machine-cycle phase counter with address latch strobe
`timescale 1ns/1ps
`default_nettype none
`include "cycle_timing_defines.svh"
module phase_counter (
  input wire logic clk_sys,
  input wire logic rstn,
  phase_if.gen ph
);
  logic [1:0] phase_q;
  // two-bit phase wraps every four clocks
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) phase_q <= 2'h0;
    else phase_q <= phase_q + 2'h1;
  end
  assign ph.phase = phase_q;
  assign ph.mc_end = (phase_q == `PHASE_LAST);
  assign ph.ale = (phase_q == 2'h0); // one strobe per cycle
endmodule : phase_counter
`default_nettype wire

// file: fast_core_cycle_timing.sv
// machine-cycle sequencer and instruction timing for the fast core
`timescale 1ns/1ps
`default_nettype none
`include "cycle_timing_defines.svh"
module fast_core_cycle_timing (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic instr_start,
  input wire logic [2:0] instr_cycles,
  input wire logic instr_xdata,
  input wire logic [2:0] stretch,
  input wire logic timer_fast,
  input wire logic [7:0] rel_byte,
  input wire logic [15:0] pc_next,
  input wire logic [10:0] short_target,
  input wire logic [15:0] long_target,
  input wire logic long_jump,
  input wire logic [7:0] imm_lo,
  input wire logic [7:0] imm_hi,
  input wire logic imm_wide,
  input wire logic ind_sel,
  input wire logic [7:0] reg0_val,
  input wire logic [7:0] reg1_val,
  output logic ale,
  output logic [1:0] phase,
  output logic mc_tick,
  output logic busy,
  output logic instr_done,
  output logic timer_tick,
  output logic [15:0] branch_target,
  output logic [15:0] jump_target,
  output logic [15:0] imm_value,
  output logic [7:0] ind_addr
);
  phase_if ph ();
  cycle_timing_pkg::seq_state_t state_q, state_d;
  logic [2:0] mc_left_q, mc_left_d;
  logic [3:0] tdiv_q;
  logic timer_tick_q, done_q;
  logic [15:0] branch_q, jump_q, imm_q;
  logic [7:0] ind_q;

  phase_counter u_phase (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ph(ph)
  );

  assign ale = ph.ale;
  assign phase = ph.phase;
  assign mc_tick = ph.mc_end;

  // legal length clamp; xdata length is base plus stretch up to stretch 6, and base at stretch 7
  wire [2:0] len_clamped = (instr_cycles < `MC_MIN) ? `MC_MIN :
                           (instr_cycles > `MC_MAX) ? `MC_MAX : instr_cycles;
  wire [3:0] x_len = {1'b0, `XDATA_BASE_MC} + {1'b0, stretch};
  wire accept = (state_q == cycle_timing_pkg::ST_FETCH) && instr_start &&
                ph.mc_end;

  // sequencer steps only on machine-cycle wrap
  always_comb begin
    state_d = state_q;
    mc_left_d = mc_left_q;
    if (ph.mc_end) begin
      unique case (state_q)
        cycle_timing_pkg::ST_FETCH: begin
          if (instr_start) begin
            if (instr_xdata) begin
              state_d = cycle_timing_pkg::ST_XDATA;
              mc_left_d = x_len[2:0] - 3'h1;
            end else begin
              state_d = cycle_timing_pkg::ST_EXEC;
              mc_left_d = len_clamped - 3'h1;
            end
            if (!instr_xdata && len_clamped == `MC_MIN)
              state_d = cycle_timing_pkg::ST_FETCH;
          end
        end
        cycle_timing_pkg::ST_EXEC,
        cycle_timing_pkg::ST_XDATA: begin
          if (mc_left_q <= 3'h1) begin
            state_d = cycle_timing_pkg::ST_FETCH;
            mc_left_d = 3'h0;
          end else mc_left_d = mc_left_q - 3'h1;
        end
        default: state_d = cycle_timing_pkg::ST_FETCH;
      endcase
    end
  end

  // static state registers, no dynamic storage
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= cycle_timing_pkg::ST_FETCH;
      mc_left_q <= 3'h0;
    end else begin
      state_q <= state_d;
      mc_left_q <= mc_left_d;
    end
  end

  wire last_mc = ph.mc_end &&
    ((accept && !instr_xdata && len_clamped == `MC_MIN) ||
     (state_q != cycle_timing_pkg::ST_FETCH && mc_left_q <= 3'h1));

  // completion pulse, registered
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) done_q <= 1'b0;
    else done_q <= last_mc;
  end
  assign instr_done = done_q;
  assign busy = (state_q != cycle_timing_pkg::ST_FETCH);

  // timer prescaler: 12 clocks while timer_fast is low, 4 while it is high
  wire [3:0] tdiv_lim = timer_fast ? `TMR_DIV_FAST : `TMR_DIV_SLOW;
  wire tdiv_wrap = (tdiv_q >= tdiv_lim - 4'h1);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tdiv_q <= 4'h0;
      timer_tick_q <= 1'b0;
    end else begin
      tdiv_q <= tdiv_wrap ? 4'h0 : tdiv_q + 4'h1;
      timer_tick_q <= tdiv_wrap;
    end
  end
  assign timer_tick = timer_tick_q;

  // operand decode; results match legacy semantics
  wire [15:0] rel_ext = {{8{rel_byte[7]}}, rel_byte};
  wire [15:0] br_d = pc_next + rel_ext;
  wire [15:0] jmp_d = long_jump ? long_target :
                      {pc_next[15:11], short_target};
  wire [15:0] imm_d = imm_wide ? {imm_hi, imm_lo} : {8'h00, imm_lo};
  cycle_timing_pkg::ind_sel_t ind_pick;
  assign ind_pick = cycle_timing_pkg::ind_sel_t'({1'b0, ind_sel});
  wire [7:0] ind_d = (ind_pick == cycle_timing_pkg::IND_R1) ?
                     reg1_val : reg0_val;

  // operand results latched when an instruction is accepted
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      branch_q <= 16'h0000;
      jump_q <= 16'h0000;
      imm_q <= 16'h0000;
      ind_q <= 8'h00;
    end else if (accept) begin
      branch_q <= br_d;
      jump_q <= jmp_d;
      imm_q <= imm_d;
      ind_q <= ind_d;
    end
  end
  assign branch_target = branch_q;
  assign jump_target = jump_q;
  assign imm_value = imm_q;
  assign ind_addr = ind_q;

  // assertions
  property p_ale_period;
    @(posedge clk_sys) disable iff (!rstn)
      ale |=> !ale [*3] ##1 ale;
  endproperty
  a_ale_period: assert property (p_ale_period)
    else $error("ale not every four clocks");

  property p_ale_phase;
    @(posedge clk_sys) disable iff (!rstn)
      ale |-> phase == 2'h0;
  endproperty
  a_ale_phase: assert property (p_ale_phase)
    else $error("ale outside phase zero");

  // clocks since the last timer tick, and whether the rate select moved
  // in between; a tick is only judged over an interval of one rate
  logic [3:0] tick_gap_q;
  logic tick_rate_q, tick_mixed_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tick_gap_q <= 4'h0;
      tick_rate_q <= 1'b0;
      tick_mixed_q <= 1'b1;
    end else if (timer_tick) begin
      tick_gap_q <= 4'h1;
      tick_rate_q <= timer_fast;
      tick_mixed_q <= 1'b0;
    end else begin
      if (tick_gap_q != 4'hf) tick_gap_q <= tick_gap_q + 4'h1;
      if (timer_fast != tick_rate_q) tick_mixed_q <= 1'b1;
    end
  end

  property p_slow_timer;
    @(posedge clk_sys) disable iff (!rstn)
      (timer_tick && !tick_mixed_q && !tick_rate_q) |->
        tick_gap_q == `TMR_DIV_SLOW;
  endproperty
  a_slow_timer: assert property (p_slow_timer)
    else $error("slow timer tick not at twelve clocks");

  property p_fast_timer;
    @(posedge clk_sys) disable iff (!rstn)
      (timer_tick && !tick_mixed_q && tick_rate_q) |->
        tick_gap_q == `TMR_DIV_FAST;
  endproperty
  a_fast_timer: assert property (p_fast_timer)
    else $error("fast timer tick not at four clocks");

  sequence s_xdata_start;
    accept && instr_xdata && stretch == 3'h0;
  endsequence
  property p_xdata_len;
    @(posedge clk_sys) disable iff (!rstn)
      s_xdata_start |-> ##1 (!instr_done [*4]) ##1 instr_done;
  endproperty
  a_xdata_len: assert property (p_xdata_len)
    else $error("external data move not eight clocks");

  property p_three_mc;
    @(posedge clk_sys) disable iff (!rstn)
      (accept && !instr_xdata && instr_cycles == 3'h3) |->
        ##1 (!instr_done [*8]) ##1 instr_done;
  endproperty
  a_three_mc: assert property (p_three_mc)
    else $error("three-cycle instruction not twelve clocks");

  property p_one_mc;
    @(posedge clk_sys) disable iff (!rstn)
      (accept && !instr_xdata && instr_cycles == 3'h1) |=> instr_done;
  endproperty
  a_one_mc: assert property (p_one_mc)
    else $error("one-cycle instruction not four clocks");

  property p_max_len;
    @(posedge clk_sys) disable iff (!rstn)
      (accept && !instr_xdata) |-> ##[1:20] instr_done;
  endproperty
  a_max_len: assert property (p_max_len)
    else $error("instruction longer than five machine cycles");

  property p_stretch;
    @(posedge clk_sys) disable iff (!rstn)
      (accept && instr_xdata && stretch == 3'h1) |->
        ##1 (!instr_done [*8]) ##1 instr_done;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("stretched data move length wrong");

  property p_rel;
    @(posedge clk_sys) disable iff (!rstn)
      accept |=> branch_target == $past(pc_next) + {{8{$past(rel_byte[7])}},
                                                  $past(rel_byte)};
  endproperty
  a_rel: assert property (p_rel)
    else $error("relative target wrong");

  property p_ind;
    @(posedge clk_sys) disable iff (!rstn)
      accept |=> ind_addr == ($past(ind_sel) ? $past(reg1_val) :
                              $past(reg0_val));
  endproperty
  a_ind: assert property (p_ind)
    else $error("indirect register selection wrong");
endmodule : fast_core_cycle_timing
`default_nettype wire

// file: code_mem_model.sv
// operand byte store standing in for external program memory
`timescale 1ns/1ps
`default_nettype none
module code_mem_model (
  input wire logic [3:0] addr,
  output logic [7:0] byte0,
  output logic [7:0] byte1,
  output logic [7:0] byte2
);
  // each byte is a fixed pattern of its own address
  function automatic logic [7:0] rom(input logic [3:0] a);
    return {a, 4'h0} ^ 8'h9c;
  endfunction : rom
  // three consecutive operand bytes from one address
  assign byte0 = rom(addr);
  assign byte1 = rom(addr + 4'h1);
  assign byte2 = rom(addr + 4'h2);
endmodule : code_mem_model
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the machine-cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0, clk_en = 1'b1, rstn = 1'b0, instr_start = 1'b0;
  logic instr_xdata = 1'b0, timer_fast = 1'b0, long_jump = 1'b0;
  logic imm_wide = 1'b0, ind_sel = 1'b0;
  logic [2:0] instr_cycles = 3'h1, stretch = 3'h0;
  logic [3:0] code_addr = 4'h0;
  logic [15:0] pc_next = 16'h0, long_target = 16'h0;
  logic [10:0] short_target = 11'h0;
  logic [7:0] reg0_val = 8'h11, reg1_val = 8'h22;
  wire logic [7:0] rel_byte, imm_lo, imm_hi;
  logic ale, mc_tick, busy, instr_done, timer_tick;
  logic [1:0] phase;
  logic [15:0] branch_target, jump_target, imm_value;
  logic [7:0] ind_addr;
  int err_count = 0, comparisons = 0, cycles = 0;

  fast_core_cycle_timing i_fast_core_cycle_timing (.clk_sys, .rstn,
    .instr_start, .instr_cycles, .instr_xdata, .stretch, .timer_fast,
    .rel_byte, .pc_next, .short_target, .long_target, .long_jump, .imm_lo,
    .imm_hi, .imm_wide, .ind_sel, .reg0_val, .reg1_val, .ale, .phase,
    .mc_tick, .busy, .instr_done, .timer_tick, .branch_target,
    .jump_target, .imm_value, .ind_addr);
  code_mem_model i_code_mem_model (.addr(code_addr), .byte0(rel_byte),
    .byte1(imm_lo), .byte2(imm_hi));

  // clock, which can be held still to show the state is kept
  always #5 clk_sys = clk_en ? ~clk_sys : clk_sys;

  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // clocks from now to the next sampled pulse of done or timer tick
  task automatic gap(input bit tmr, output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while ((tmr ? timer_tick : instr_done) !== 1'b1 && n < 100);
  endtask : gap

  // back-to-back instructions of one kind; second done-to-done gap measured
  task automatic run(input logic [2:0] n, input logic xd,
                     input logic [2:0] st, input int exp);
    int c;
    @(posedge clk_sys);
    instr_cycles <= n;
    instr_xdata <= xd;
    stretch <= st;
    instr_start <= 1'b1;
    gap(1'b0, c);
    gap(1'b0, c);
    gap(1'b0, c);
    check(16'(c), 16'(exp));
    // one cycle after the next accept; only multi-cycle kinds are busy
    repeat (3) @(posedge clk_sys);
    #1;
    check(busy, exp > 4);
  endtask : run

  task automatic t_reset();
    repeat (7) @(posedge clk_sys);
    #1;
    check(phase, 2'h0);
    check({ale, busy, instr_done, timer_tick}, 4'h8);
    @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    #1;
    check(phase, 2'h1);
  endtask : t_reset

  task automatic t_phase();
    logic [1:0] p;
    p = 2'h1; // phase one edge after reset release
    for (int i = 1; i <= 8; i++) begin
      @(posedge clk_sys);
      #1;
      p = p + 2'h1;
      check(phase, p);
      check(ale, p == 2'h0);
      check(mc_tick, p == 2'h3);
    end
  endtask : t_phase

  task automatic t_timer();
    int c;
    gap(1'b1, c);
    gap(1'b1, c);
    check(16'(c), 16'd12);
    timer_fast <= 1'b1;
    gap(1'b1, c);
    gap(1'b1, c);
    check(16'(c), 16'd4);
  endtask : t_timer

  // stop the clock for a while; the phase must resume where it stood
  task automatic t_static();
    logic [1:0] p;
    @(posedge clk_sys);
    #1;
    p = phase;
    clk_en = 1'b0;
    #200;
    clk_en = 1'b1;
    check(phase, p);
    @(posedge clk_sys);
    #1;
    check(phase, 2'(p + 2'h1));
  endtask : t_static

  task automatic t_operands();
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      code_addr <= k ? 4'h9 : 4'h2;
      pc_next <= k ? 16'hfff0 : 16'h1234;
      short_target <= 11'h5a5;
      long_target <= 16'hbeef;
      long_jump <= k[0];
      imm_wide <= k[0];
      ind_sel <= !k[0];
      run(3'h1, 1'b0, 3'h0, 4);
      #1;
      // operand bytes: addr 2 gives bc ac dc, addr 9 gives 0c 3c 2c
      check(branch_target, k ? 16'hfffc : 16'h11f0);
      check(jump_target, k ? 16'hbeef : 16'h15a5);
      check(imm_value, k ? 16'h2c3c : 16'h00ac);
      check(ind_addr, k ? 16'h0011 : 16'h0022);
    end
  endtask : t_operands

  task automatic finish_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  initial begin
    t_reset();
    t_phase();
    t_timer();
    t_static();
    for (int n = 0; n < 8; n++) begin
      run(3'(n), 1'b0, 3'h0, n == 0 ? 4 : (n > 5 ? 20 : 4 * n));
    end
    run(3'h1, 1'b1, 3'h0, 8);
    run(3'h1, 1'b1, 3'h1, 12);
    run(3'h1, 1'b1, 3'h3, 20);
    run(3'h1, 1'b1, 3'h5, 28);
    t_operands();
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
